/* File: hdl/sync_serial_port.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1: three formats: pulsed, polarity/phase, message
// RULE2: data field 4 to 16 bits
// RULE3: most significant bit shifted first
// RULE4: serial clock low while idle
// RULE5: serial clock toggles only inside frames
// RULE6: frame_sync marks frame start and end
// RULE7: drive enable for external line driver
// RULE8: pulsed format: sync high one period
// RULE9: pulsed format: drive rising, sample falling
// RULE10: polarity and phase each selectable
// RULE11: message format: sync low whole frame
// RULE12: message format: drive falling, sample rising
// RULE13: message format runs half duplex
// RULE14: message frame opens with 8-bit control
// RULE15: no receive during control message
// RULE16: slave waits one period before reply
// RULE17: reply 4 to 16 bits, 13-25 total
// RULE18: continuous: next word follows immediately
// RULE19: phase picks first or second capture edge
module sync_serial_port (
    // system clock, link clock, reset
    input  wire logic        clk,
    input  wire logic        link_clk,
    input  wire logic        arst_n,
    // transmit word and frame settings, taken together
    input  wire logic [15:0] tx_data,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    input  wire logic [1:0]  frame_format,
    input  wire logic [4:0]  data_size,
    input  wire logic        clock_polarity_sel,
    input  wire logic        clock_phase_sel,
    // receive word
    output logic [15:0]      rx_data,
    output logic             rx_valid,
    // status
    output logic             link_busy,
    // serial pins
    output logic             serial_clock_out,
    output logic             frame_sync,
    output logic             serial_data_out,
    output logic             line_driver_enable_n,
    input  wire logic        serial_data_in
);

    // keeps a requested size inside the legal range
    function automatic logic [4:0] clamp_size(input logic [4:0] n);
        logic [4:0] r;
        r = n;
        if (n < serial_pkg::SIZE_MIN) r = serial_pkg::SIZE_MIN;
        else if (n > serial_pkg::SIZE_MAX) r = serial_pkg::SIZE_MAX;
        return r;
    endfunction : clamp_size

    // low n bits set
    function automatic logic [15:0] size_mask(input logic [4:0] n);
        logic [16:0] m;
        m = (17'h00001 << n) - 17'h00001;
        return m[15:0];
    endfunction : size_mask

    // ---------------- system clock side ----------------
    logic [15:0] tx_hold_ff;      // word waiting for the link, stable until acked
    logic [1:0]  fmt_hold_ff;     // settings that travel with the word
    logic [4:0]  size_hold_ff;
    logic        cpol_hold_ff;
    logic        cpha_hold_ff;
    logic        tx_full_ff;      // hold register owned by the link
    logic        req_tgl_ff;      // toggles once per word handed over
    logic        ack_s;           // link acknowledge, synchronised
    logic        ack_seen_ff;
    logic        rx_s;            // receive toggle, synchronised
    logic        rx_seen_ff;
    logic [15:0] rx_data_ff;
    logic        rx_valid_ff;
    logic        tx_accept;
    logic        ack_edge;
    logic        rx_edge;
    logic        nxt_tx_full;

    // ---------------- link clock side ----------------
    serial_pkg::state_t state_ff;
    serial_pkg::state_t nxt_state;
    logic        req_s;           // word request, synchronised
    logic        req_seen_ff;
    logic        pend_ff;         // a word waits in the hold register
    logic        ack_tgl_ff;      // toggles when the engine takes a word
    logic        busy_ff;         // frame running or word pending
    logic [1:0]  fmt_ff;          // settings of the frame on the wire
    logic [4:0]  size_ff;
    logic        cpol_ff;
    logic        cpha_ff;
    logic [4:0]  bits_ff;         // bit periods left in this phase
    logic [4:0]  nxt_bits;
    logic [15:0] tx_sh_ff;        // outgoing bits, msb on the wire
    logic [15:0] nxt_sh;
    logic        sclk_ff;
    logic        frame_sync_ff;
    logic        sdo_ff;
    logic        lde_n_ff;
    logic        sdi_s;           // serial input after two flops
    logic [1:0]  cap_pipe_ff;     // sample strobes aligned to sdi_s
    logic [1:0]  last_pipe_ff;    // final-sample strobes, same alignment
    logic [15:0] rx_sh_ff;
    logic [15:0] rx_mask_ff;
    logic [15:0] rx_word_ff;      // finished word, stable until next frame ends
    logic        rx_tgl_ff;
    logic        req_edge;
    logic        active;
    logic        half;
    logic        period_end;
    logic        load;
    logic        is_pulsed;
    logic        is_msg;
    logic        is_spi;
    logic        lead;
    logic        sample_c;
    logic        last_c;
    logic        sclk_c;
    logic        sync_c;
    logic        sdo_c;
    logic        lde_n_c;
    serial_pkg::state_t first_state;
    logic [4:0]  first_bits;
    logic [15:0] first_sh;
    logic [4:0]  align_amt;

    bit_timer_if tmr_if ();

    // ================= system clock domain =================
    assign tx_ready    = ~tx_full_ff;
    assign tx_accept   = tx_valid & ~tx_full_ff;
    assign ack_edge    = ack_s ^ ack_seen_ff;
    assign rx_edge     = rx_s ^ rx_seen_ff;
    // a new word can only be accepted once the link has released the last one
    assign nxt_tx_full = tx_accept | (tx_full_ff & ~ack_edge);
    assign rx_data     = rx_data_ff;
    assign rx_valid    = rx_valid_ff;

    // capture a word together with its frame settings
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_hold_ff   <= serial_pkg::RST_WORD;
            fmt_hold_ff  <= serial_pkg::RST_FMT;
            size_hold_ff <= serial_pkg::RST_SIZE;
            cpol_hold_ff <= 1'b0;
            cpha_hold_ff <= 1'b0;
        end else if (tx_accept) begin
            tx_hold_ff   <= tx_data;
            fmt_hold_ff  <= frame_format;
            size_hold_ff <= clamp_size(data_size); // RULE2
            cpol_hold_ff <= clock_polarity_sel;    // RULE10
            cpha_hold_ff <= clock_phase_sel;       // RULE10
        end
    end

    // handshake toward the link and receive word pickup
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_full_ff  <= 1'b0;
            req_tgl_ff  <= 1'b0;
            ack_seen_ff <= 1'b0;
            rx_seen_ff  <= 1'b0;
            rx_data_ff  <= serial_pkg::RST_WORD;
            rx_valid_ff <= 1'b0;
        end else begin
            tx_full_ff  <= nxt_tx_full;
            req_tgl_ff  <= req_tgl_ff ^ tx_accept;
            ack_seen_ff <= ack_s;
            rx_seen_ff  <= rx_s;
            rx_valid_ff <= rx_edge;
            if (rx_edge) rx_data_ff <= rx_word_ff;
        end
    end

    serial_sync_bit u_ack_sync  (.clk(clk), .arst_n(arst_n), .d(ack_tgl_ff), .q(ack_s));
    serial_sync_bit u_rx_sync   (.clk(clk), .arst_n(arst_n), .d(rx_tgl_ff),  .q(rx_s));
    serial_sync_bit u_busy_sync (.clk(clk), .arst_n(arst_n), .d(busy_ff),    .q(link_busy));

    // ================= link clock domain =================
    serial_sync_bit u_req_sync (.clk(link_clk), .arst_n(arst_n), .d(req_tgl_ff), .q(req_s));
    serial_sync_bit u_sdi_sync (.clk(link_clk), .arst_n(arst_n), .d(serial_data_in), .q(sdi_s));
    serial_bit_timer u_timer   (.clk(link_clk), .arst_n(arst_n), .tmr(tmr_if));

    assign tmr_if.run = active;
    assign half       = tmr_if.half;
    assign req_edge   = req_s ^ req_seen_ff;
    assign active     = (state_ff != serial_pkg::ST_IDLE);
    assign period_end = active & half;

    // format decode; an unused code behaves as the polarity/phase format
    assign is_pulsed = (fmt_ff == serial_pkg::FMT_PULSED);  // RULE1
    assign is_msg    = (fmt_ff == serial_pkg::FMT_MSG);     // RULE1
    assign is_spi    = ~is_pulsed & ~is_msg;                // RULE1

    // take the pending word when idle or right at the end of a frame
    assign load = pend_ff & ((state_ff == serial_pkg::ST_IDLE) |
                  (period_end & (state_ff == serial_pkg::ST_DATA) &
                   (bits_ff == serial_pkg::BITS_LAST)));    // RULE18

    // opening of a frame, decided from the word's own settings
    assign align_amt   = serial_pkg::WORD_BITS - size_hold_ff;
    assign first_state = (fmt_hold_ff == serial_pkg::FMT_PULSED) ? serial_pkg::ST_SYNC :
                         (fmt_hold_ff == serial_pkg::FMT_MSG)    ? serial_pkg::ST_CTRL :
                                                                   serial_pkg::ST_DATA;
    assign first_bits  = (fmt_hold_ff == serial_pkg::FMT_MSG) ? serial_pkg::CTRL_BITS // RULE14
                                                              : size_hold_ff;         // RULE2
    // left-align so the field's msb leaves first; message frames send the low byte
    assign first_sh    = (fmt_hold_ff == serial_pkg::FMT_MSG) ? {tx_hold_ff[7:0], 8'h00}
                                                              : (tx_hold_ff << align_amt); // RULE3

    // frame sequencer, one step per bit period
    always_comb begin
        nxt_state = state_ff;
        nxt_bits  = bits_ff;
        nxt_sh    = tx_sh_ff;
        unique case (state_ff)
            serial_pkg::ST_IDLE: begin
                if (load) begin
                    nxt_state = first_state;
                    nxt_bits  = first_bits;
                    nxt_sh    = first_sh;
                end
            end
            serial_pkg::ST_SYNC: begin
                if (period_end) begin
                    nxt_state = serial_pkg::ST_DATA;
                    nxt_bits  = size_ff;
                end
            end
            serial_pkg::ST_CTRL: begin
                if (period_end) begin
                    nxt_sh = {tx_sh_ff[14:0], 1'b0};               // RULE3
                    if (bits_ff == serial_pkg::BITS_LAST) begin
                        nxt_state = serial_pkg::ST_TURN;           // RULE16
                    end else begin
                        nxt_bits = bits_ff - serial_pkg::BITS_LAST;
                    end
                end
            end
            serial_pkg::ST_TURN: begin
                // one idle period while the slave decodes the message
                if (period_end) begin
                    nxt_state = serial_pkg::ST_DATA;               // RULE16
                    nxt_bits  = size_ff;                           // RULE17
                end
            end
            serial_pkg::ST_DATA: begin
                if (period_end) begin
                    nxt_sh = {tx_sh_ff[14:0], 1'b0};               // RULE3
                    if (bits_ff != serial_pkg::BITS_LAST) begin
                        nxt_bits = bits_ff - serial_pkg::BITS_LAST;
                    end else if (load) begin
                        nxt_state = first_state;                   // RULE18
                        nxt_bits  = first_bits;
                        nxt_sh    = first_sh;
                    end else begin
                        nxt_state = serial_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_state = serial_pkg::ST_IDLE;
            end
        endcase
    end

    // pin levels for the coming cycle
    // the level in the first half of a bit: rising start for pulsed, falling
    // start for message, and polarity xor phase otherwise
    assign lead    = is_pulsed ? 1'b1 :                                  // RULE9
                     is_msg    ? 1'b0 :                                  // RULE12
                                 (cpol_ff ^ cpha_ff);                    // RULE10 RULE19
    assign sclk_c  = active ? (half ? ~lead : lead) : 1'b0;              // RULE4 RULE5
    assign sync_c  = is_pulsed ? (state_ff == serial_pkg::ST_SYNC)       // RULE8
                               : ~active;                                // RULE6 RULE11
    assign sdo_c   = ((state_ff == serial_pkg::ST_CTRL) |
                      ((state_ff == serial_pkg::ST_DATA) & ~is_msg)) & tx_sh_ff[15];
    // the external driver is released while the slave replies
    assign lde_n_c = ~(active & ~(is_msg & ((state_ff == serial_pkg::ST_TURN) |
                                            (state_ff == serial_pkg::ST_DATA)))); // RULE7 RULE13
    // input is captured at mid-period, only in the data phase
    assign sample_c = (state_ff == serial_pkg::ST_DATA) & half;          // RULE15 RULE19
    assign last_c   = sample_c & (bits_ff == serial_pkg::BITS_LAST);

    // sequencer state and settings of the frame on the wire
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= serial_pkg::ST_IDLE;
            bits_ff  <= serial_pkg::RST_SIZE;
            tx_sh_ff <= serial_pkg::RST_WORD;
            fmt_ff   <= serial_pkg::RST_FMT;
            size_ff  <= serial_pkg::RST_SIZE;
            cpol_ff  <= 1'b0;
            cpha_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            bits_ff  <= nxt_bits;
            tx_sh_ff <= nxt_sh;
            if (load) begin
                fmt_ff  <= fmt_hold_ff;
                size_ff <= size_hold_ff;
                cpol_ff <= cpol_hold_ff;
                cpha_ff <= cpha_hold_ff;
            end
        end
    end

    // registered pins and word handshake
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_ff       <= 1'b0;
            frame_sync_ff <= serial_pkg::RST_SYNC;
            sdo_ff        <= 1'b0;
            lde_n_ff      <= serial_pkg::RST_LDE_N;
            req_seen_ff   <= 1'b0;
            pend_ff       <= 1'b0;
            ack_tgl_ff    <= 1'b0;
            busy_ff       <= 1'b0;
        end else begin
            sclk_ff       <= sclk_c;
            frame_sync_ff <= sync_c;
            sdo_ff        <= sdo_c;
            lde_n_ff      <= lde_n_c;
            req_seen_ff   <= req_s;
            pend_ff       <= req_edge | (pend_ff & ~load);
            ack_tgl_ff    <= ack_tgl_ff ^ load;
            busy_ff       <= active | pend_ff;
        end
    end

    // receive path: pins lag one cycle and sdi_s two more, so strobes are delayed
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            cap_pipe_ff  <= 2'h0;
            last_pipe_ff <= 2'h0;
            rx_sh_ff     <= serial_pkg::RST_WORD;
            rx_mask_ff   <= serial_pkg::RST_WORD;
            rx_word_ff   <= serial_pkg::RST_WORD;
            rx_tgl_ff    <= 1'b0;
        end else begin
            cap_pipe_ff  <= {cap_pipe_ff[0], sample_c};
            last_pipe_ff <= {last_pipe_ff[0], last_c};
            if (last_c) rx_mask_ff <= size_mask(size_ff);             // RULE17
            if (cap_pipe_ff[1]) rx_sh_ff <= {rx_sh_ff[14:0], sdi_s};  // RULE3 RULE15
            if (last_pipe_ff[1]) begin
                rx_word_ff <= {rx_sh_ff[14:0], sdi_s} & rx_mask_ff;
                rx_tgl_ff  <= ~rx_tgl_ff;
            end
        end
    end

    assign serial_clock_out     = sclk_ff;
    assign frame_sync           = frame_sync_ff;
    assign serial_data_out      = sdo_ff;
    assign line_driver_enable_n = lde_n_ff;

    // ---------------- checks on the link side ----------------
    property p_idle_low;
        @(posedge link_clk) disable iff (!arst_n)
        (state_ff == serial_pkg::ST_IDLE) |=> !sclk_ff;
    endproperty
    a_idle_low: assert property (p_idle_low) // RULE4
        else $error("serial clock not low while idle");

    property p_clk_static;
        @(posedge link_clk) disable iff (!arst_n)
        $changed(sclk_ff) |-> (($past(state_ff) != serial_pkg::ST_IDLE) ||
                               ($past(state_ff, 2) != serial_pkg::ST_IDLE));
    endproperty
    a_clk_static: assert property (p_clk_static) // RULE5
        else $error("serial clock moved outside a frame");

    property p_pulse_one_period;
        @(posedge link_clk) disable iff (!arst_n)
        (state_ff == serial_pkg::ST_SYNC && !half) |=>
            (frame_sync_ff && sclk_ff) ##1 (frame_sync_ff && !sclk_ff) ##1 !frame_sync_ff;
    endproperty
    a_pulse_one_period: assert property (p_pulse_one_period) // RULE8
        else $error("frame pulse not one clock period from rising edge");

    property p_pulsed_fall_sample;
        @(posedge link_clk) disable iff (!arst_n)
        (is_pulsed && sample_c) |=> $fell(sclk_ff);
    endproperty
    a_pulsed_fall_sample: assert property (p_pulsed_fall_sample) // RULE9
        else $error("pulsed format sample not on falling edge");

    property p_msg_rise_sample;
        @(posedge link_clk) disable iff (!arst_n)
        (is_msg && sample_c) |=> $rose(sclk_ff);
    endproperty
    a_msg_rise_sample: assert property (p_msg_rise_sample) // RULE12
        else $error("message format sample not on rising edge");

    property p_spi_edge;
        @(posedge link_clk) disable iff (!arst_n)
        (is_spi && sample_c) |=> $changed(sclk_ff) && (sclk_ff == ~$past(cpol_ff ^ cpha_ff));
    endproperty
    a_spi_edge: assert property (p_spi_edge) // RULE19
        else $error("capture edge does not follow polarity and phase");

    property p_msg_sync_low;
        @(posedge link_clk) disable iff (!arst_n)
        (is_msg && active) |=> !frame_sync_ff;
    endproperty
    a_msg_sync_low: assert property (p_msg_sync_low) // RULE11
        else $error("message frame sync not low during frame");

    property p_half_duplex;
        @(posedge link_clk) disable iff (!arst_n)
        (is_msg && state_ff == serial_pkg::ST_DATA) |=> lde_n_ff && !sdo_ff;
    endproperty
    a_half_duplex: assert property (p_half_duplex) // RULE13
        else $error("driver still enabled during reply");

    property p_ctrl_len;
        @(posedge link_clk) disable iff (!arst_n)
        $rose(state_ff == serial_pkg::ST_CTRL) |-> ##16 (state_ff == serial_pkg::ST_TURN);
    endproperty
    a_ctrl_len: assert property (p_ctrl_len) // RULE14
        else $error("control message not eight bit periods");

    property p_ctrl_no_rx;
        @(posedge link_clk) disable iff (!arst_n)
        (state_ff == serial_pkg::ST_CTRL) |-> ##3 $stable(rx_sh_ff);
    endproperty
    a_ctrl_no_rx: assert property (p_ctrl_no_rx) // RULE15
        else $error("receive data taken during control message");

    property p_turn_one_period;
        @(posedge link_clk) disable iff (!arst_n)
        $rose(state_ff == serial_pkg::ST_TURN) |->
            ##1 (state_ff == serial_pkg::ST_TURN) ##1 (state_ff == serial_pkg::ST_DATA);
    endproperty
    a_turn_one_period: assert property (p_turn_one_period) // RULE16
        else $error("turnaround not one clock period");

endmodule : sync_serial_port

`default_nettype wire

/* File: hdl/serial_pkg.sv */
`default_nettype none

package serial_pkg;

    // frame format codes on the frame_format port
    localparam logic [1:0] FMT_PULSED  = 2'h0;   // pulsed frame sync, full duplex
    localparam logic [1:0] FMT_SPI     = 2'h1;   // polarity/phase selectable, full duplex
    localparam logic [1:0] FMT_MSG     = 2'h2;   // control message then reply, half duplex

    // word and frame sizes
    localparam logic [4:0] SIZE_MIN    = 5'h04;  // shortest data field
    localparam logic [4:0] SIZE_MAX    = 5'h10;  // longest data field
    localparam logic [4:0] CTRL_BITS   = 5'h08;  // control message length
    localparam logic [4:0] BITS_LAST   = 5'h01;  // counter value in the final bit period
    localparam logic [4:0] WORD_BITS   = 5'h10;  // width of the shift registers

    // reset values
    localparam logic [1:0] RST_FMT     = FMT_SPI;  // select idles high after reset
    localparam logic [4:0] RST_SIZE    = SIZE_MAX;
    localparam logic       RST_SYNC    = 1'b1;     // frame_sync level matching RST_FMT
    localparam logic       RST_LDE_N   = 1'b1;     // off-chip driver disabled
    localparam logic [15:0] RST_WORD   = 16'h0000;

    // link engine states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SYNC = 5'h02,
        ST_CTRL = 5'h04,
        ST_TURN = 5'h08,
        ST_DATA = 5'h10
    } state_t;

endpackage : serial_pkg

`default_nettype wire

/* File: hdl/bit_timer_if.sv */
`timescale 1ns/1ps
`default_nettype none

// half-period phase shared between the link engine and its bit timer
interface bit_timer_if;
    logic run;    // a frame is in progress
    logic half;   // 0 = first half of a bit period, 1 = second half

    modport timer (input run, output half);
    modport user  (output run, input half);
endinterface : bit_timer_if

`default_nettype wire

/* File: hdl/serial_sync_bit.sv */
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for one level or toggle
module serial_sync_bit (
    // destination clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // level in from another domain, level out in this one
    input  wire logic d,
    output logic      q
);

    logic meta_ff;   // first stage, read only by the second
    logic q_ff;      // second stage, safe to use

    // plain shift through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 1'b0;
            q_ff    <= 1'b0;
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;

endmodule : serial_sync_bit

`default_nettype wire

/* File: hdl/serial_bit_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// splits each bit period into two link clock cycles
module serial_bit_timer (
    // link clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // phase toward the engine
    bit_timer_if.timer tmr
);

    logic half_ff;   // current half of the bit period

    // toggles while a frame runs, parks in the first half when idle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            half_ff <= 1'b0;
        end else begin
            half_ff <= tmr.run ? ~half_ff : 1'b0;
        end
    end

    assign tmr.half = half_ff;

endmodule : serial_bit_timer

`default_nettype wire

/* File: verif/serial_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
// slave used for all three formats: shifts out on clock fall
module serial_slave_model (
    // pins seen from the slave
    input  wire logic        sclk,
    input  wire logic        sel_n,
    output logic             sdi,
    // reply word, its length, the clock fall that brings the first bit (0: the first bit comes on selection)
    input  wire logic [15:0] word,
    input  wire logic [4:0]  size,
    input  wire logic [4:0]  skip
);
    int idx;    // index of the bit now on the line
    int falls;  // clock falls seen in this frame
    initial sdi = 1'b0;
    // with no skip the first bit appears as the slave is selected
    always @(negedge sel_n) begin
        falls = 0;
        idx = int'(size);
        if (skip == 5'h00) begin
            idx--;
            sdi = word[idx];
        end
    end
    // later bits on each fall; a message reply waits out control byte and turnaround
    always @(negedge sclk) if (!sel_n) begin
        falls++;
        if (falls >= int'(skip) && idx > 0) begin
            idx--;
            sdi = word[idx];
        end
    end
    // a released line must not show a stale bit
    always @(posedge sel_n) sdi = ~sdi;
endmodule : serial_slave_model
`default_nettype wire

/* File: verif/sync_serial_port_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch at %0t: %h %h", $time, a, b); end end
module sync_serial_port_tb_top;
    logic        clk = 0, link_clk = 0, arst_n = 0, tx_valid = 0, pol = 0, pha = 0;
    logic [15:0] tx_data = '0, rx_data, capt = '0, capf = '0;
    logic [1:0]  fmt = 2'h1;
    logic [4:0]  size = 5'h04;
    logic        tx_ready, rx_valid, link_busy, sclk, fsync, sdo, lde_n, sdi;
    int          n_errors = 0, comparisons = 0, rises = 0, released = 0, k;
    always #2.5 clk = ~clk;
    always #24 link_clk = ~link_clk;
    sync_serial_port dut_u (.clk(clk), .link_clk(link_clk), .arst_n(arst_n),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .frame_format(fmt),
        .data_size(size), .clock_polarity_sel(pol), .clock_phase_sel(pha),
        .rx_data(rx_data), .rx_valid(rx_valid), .link_busy(link_busy),
        .serial_clock_out(sclk), .frame_sync(fsync), .serial_data_out(sdo),
        .line_driver_enable_n(lde_n), .serial_data_in(sdi));
    serial_slave_model slave_u (.sclk(sclk), .sel_n(fsync), .sdi(sdi),
        .word(16'hc35a), .size(size), .skip((fmt == 2'h2) ? 5'h09 : 5'h00));
    // record the line at both clock edges, and rises with the driver released
    always @(posedge sclk) begin
        rises++;
        capt = {capt[14:0], sdo};
        if (lde_n) released++;
    end
    always @(negedge sclk) capf = {capf[14:0], sdo};
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    // a wait that used up its bound is a mismatch and ends the run
    task automatic bound(input int n);
        if (n >= 4000) begin
            n_errors++;
            close_out();
        end
    endtask : bound
    // offer one word, held until taken
    task automatic send(input logic [1:0] f, input logic [4:0] s, input logic [15:0] d);
        @(negedge clk);
        {fmt, size, tx_data, tx_valid} = {f, s, d, 1'b1};
        for (k = 0; k < 4000 && !tx_ready; k++) @(negedge clk);
        bound(k);
        @(negedge clk);
        tx_valid = 0;
    endtask : send
    // wait for the received word, then for the link to go idle
    task automatic settle(input string name);
        for (k = 0; k < 4000 && rx_valid !== 1'b1; k++) @(negedge clk);
        bound(k);
        for (k = 0; k < 4000 && link_busy !== 1'b0; k++) @(negedge clk);
        bound(k);
        $display("test %s done", name);
    endtask : settle
    initial begin
        repeat (10) @(posedge clk);
        // let the link side see two edges in reset as well
        repeat (2) @(posedge link_clk);
        @(negedge clk);
        arst_n = 1;
        // the short limit, then the long limit with capture on the second, then the first edge; msb first, reply right-aligned
        for (int i = 0; i < 3; i++) begin
            rises = 0;
            pha = (i == 1);
            send(2'h1, (i > 0) ? 5'h10 : 5'h04, 16'h9b6d);
            settle("spi");
            `CHK(rises, (i > 0) ? 16 : 4)
            `CHK(((i == 1) ? capf : capt) & ((i > 0) ? 16'hffff : 16'h000f),
                 (i > 0) ? 16'h9b6d : 16'h000d)
            `CHK(rx_data, (i > 0) ? 16'hc35a : 16'h000a)
            `CHK({sclk, fsync, lde_n}, 3'h3)
        end
        // message: 8 control, 1 turnaround, 4 reply periods
        rises = 0;
        released = 0;
        send(2'h2, 5'h04, 16'h00e1);
        settle("message");
        `CHK(rises, 13)
        `CHK(capt[12:5], 8'he1)
        `CHK(lde_n, 1'b1)
        `CHK(released, 5)
        `CHK(rx_data, 16'h000a)
        // pulsed: one sync period then data sampled on the fall
        rises = 0;
        send(2'h0, 5'h08, 16'h00a7);
        settle("pulsed");
        `CHK(rises, 9)
        `CHK(capf[7:0], 8'ha7)
        `CHK(rx_data, 16'h005a)
        // two words queued back to back
        rises = 0;
        send(2'h1, 5'h04, 16'h0005);
        send(2'h1, 5'h04, 16'h000c);
        settle("back to back");
        for (k = 0; k < 4000 && link_busy !== 1'b0; k++) @(negedge clk);
        bound(k);
        `CHK(rises, 8)
        `CHK(capt[7:0], 8'h5c)
        close_out();
    end
endmodule : sync_serial_port_tb_top
`default_nettype wire
